// ### bench/pin_driver.sv
// Model of the external logic driving the shift register pins
`timescale 1ns/1ps
module pin_driver (
	// System clock
	input wire logic sys_clk,
	// Device pins
	output logic shift_clk,
	output logic serial_a,
	output logic serial_b,
	output logic clear_n
);
	// Pins idle at time zero, clock low until the first shift and high between shifts
	initial begin
		shift_clk = 1'b0;
		serial_a = 1'b0;
		serial_b = 1'b0;
		clear_n = 1'b1;
	end

	// Low phase with data set up, then the rising edge
	task automatic shift(input logic a, input logic b);
		@(negedge sys_clk);
		shift_clk = 1'b0;
		serial_a = a;
		serial_b = b;
		@(negedge sys_clk);
		shift_clk = 1'b1;
		@(negedge sys_clk);
		serial_a = ~a; // Data moves while clock high
		serial_b = ~b;
	endtask : shift

	// Hold the clock at the given level while serial_a toggles and serial_b is driven high
	task automatic wiggle(input logic level);
		@(negedge sys_clk);
		shift_clk = level;
		serial_a = ~serial_a; // Data moves at any level
		serial_b = 1'b1;
	endtask : wiggle

	// Clear pulse with a rising clock inside it
	task automatic clear_pulse();
		@(negedge sys_clk);
		clear_n = 1'b0;
		shift_clk = 1'b0;
		@(negedge sys_clk);
		shift_clk = 1'b1;
		@(negedge sys_clk);
		clear_n = 1'b1;
	endtask : clear_pulse
endmodule : pin_driver

// ### bench/tb_gated_serial_shift_register.sv
// Self-checking bench for the gated serial shift register
`timescale 1ns/1ps
module tb_gated_serial_shift_register
	import shift_reg_pkg::*;
;
	// ------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------
	logic sys_clk, nrst, snap_ready, shift_clk, serial_a, serial_b, clear_n;
	logic [STAGE_COUNT-1:0] stage_outputs;
	logic [SNAP_WIDTH-1:0] snap_data;
	logic s1, s2, s7, s8, snap_valid, snap_space, snap_overrun;
	logic [7:0] expect_v;
	int error_cnt, checks, cyc;

	gated_serial_shift_register i_dut (.sys_clk(sys_clk), .nrst(nrst),
		.shift_clk(shift_clk), .serial_a(serial_a), .serial_b(serial_b),
		.clear_n(clear_n), .stage_outputs(stage_outputs), .stage_one_output(s1),
		.stage_two_output(s2), .stage_seven_output(s7), .stage_eight_output(s8),
		.snap_valid(snap_valid), .snap_data(snap_data), .snap_ready(snap_ready),
		.snap_space(snap_space), .snap_overrun(snap_overrun));
	pin_driver i_pins (.sys_clk(sys_clk), .shift_clk(shift_clk),
		.serial_a(serial_a), .serial_b(serial_b), .clear_n(clear_n));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] want, input logic [7:0] got);
		checks++;
		if (got !== want) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, want, got);
		end
	endtask : chk

	task automatic stop_test();
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	// One shift, judged on all stages and on the four taps
	task automatic do_shift(input logic a, input logic b);
		i_pins.shift(a, b);
		expect_v = {expect_v[6:0], a & b};
		chk("stages", expect_v, stage_outputs);
		chk("taps", {4'h0, expect_v[7:6], expect_v[1:0]}, {4'h0, s8, s7, s2, s1});
	endtask : do_shift

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Every gate combination, then a pattern through both gates
	task automatic t_gate();
		logic [7:0] pat;
		pat = 8'hA5;
		for (int i = 0; i < 4; i++) begin
			do_shift(i[1], i[0]);
		end
		for (int i = 0; i < 8; i++) begin
			do_shift(pat[i], 1'b1);
			do_shift(1'b1, pat[7-i]);
		end
	endtask : t_gate

	// Clock held high, then a falling edge and held low: nothing moves
	task automatic t_hold();
		for (int i = 0; i < 6; i++) begin
			i_pins.wiggle(logic'(i < 3));
			chk("hold", expect_v, stage_outputs);
		end
		@(negedge sys_clk);
		chk("hold last", expect_v, stage_outputs);
	endtask : t_hold

	// Clear wins over a rising clock in the same pulse
	task automatic t_clear();
		i_pins.clear_pulse();
		expect_v = 8'h00;
		chk("clear", expect_v, stage_outputs);
		do_shift(1'b1, 1'b1);
	endtask : t_clear

	// Stalled reader: fill until a snapshot drops, then drain in order
	task automatic t_fifo();
		logic [7:0] snaps[$];
		repeat (4) @(negedge sys_clk);
		snap_ready = 1'b0;
		for (int i = 0; i < 18; i++) begin
			do_shift(i[0] ^ i[2], 1'b1);
			if (i < 17) snaps.push_back(expect_v);
		end
		repeat (3) @(negedge sys_clk);
		chk("space", 8'h00, snap_space);
		chk("overrun", 8'h01, snap_overrun);
		snap_ready = 1'b1;
		for (int i = 0; i < 60 && snaps.size() > 0; i++) begin
			if (snap_valid === 1'b1) chk("snap", snaps.pop_front(), snap_data);
			@(negedge sys_clk);
		end
		chk("left", 8'h00, snaps.size());
		chk("valid", 8'h00, snap_valid);
		chk("space back", 8'h01, snap_space);
	endtask : t_fifo

	// Reset in mid-run: outputs back to rest, a clock held high is no edge
	task automatic t_reset();
		@(negedge sys_clk);
		nrst = 1'b0;
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		expect_v = STAGE_RESET;
		chk("rst stages", expect_v, stage_outputs);
		chk("rst overrun", 8'h00, snap_overrun);
		chk("rst valid", 8'h00, snap_valid);
		chk("rst space", 8'h01, snap_space);
		repeat (2) @(negedge sys_clk);
		chk("rst edge", expect_v, stage_outputs);
		do_shift(1'b1, 1'b1);
	endtask : t_reset

	// ------------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Ceiling well above the fewer than two hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		nrst = 1'b0;
		snap_ready = 1'b1;
		expect_v = 8'h00;
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		nrst = 1'b1;
		chk("reset", STAGE_RESET, stage_outputs);
		chk("reset space", 8'h01, snap_space);
		t_gate();
		t_hold();
		t_clear();
		t_fifo();
		t_reset();
		stop_test();
	end
endmodule : tb_gated_serial_shift_register

// ### hw/gated_serial_shift_register.sv
// Eight-stage gated serial-in parallel-out shift register with snapshot stream
//
// Function
// - Eight cascaded stages, each with its own parallel output, fed at the first stage by a gated pair of serial inputs.
// - While clear is low every stage is forced low whatever the clock and serial inputs do.
// - A low on either serial input or both at a rising clock edge loads a low into the first stage.
// - With one serial input high the other decides the first stage, and both high load a high.
// - Apart from clear, stages change only on the low-to-high transition of the shift clock.
// - On each rising edge stages two to eight take the previous value of the stage before them.
// - With clear inactive and no rising edge every stage holds its level.
// - Serial inputs may change at any clock level; only the values sampled at the rising edge count.
`timescale 1ns/1ps
module gated_serial_shift_register
	import shift_reg_pkg::*;
(
	// System clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Device pins, synchronous to sys_clk
	input wire logic shift_clk,
	input wire logic serial_a,
	input wire logic serial_b,
	input wire logic clear_n,
	// Parallel stage outputs
	output logic [STAGE_COUNT-1:0] stage_outputs,
	output logic stage_one_output,
	output logic stage_two_output,
	output logic stage_seven_output,
	output logic stage_eight_output,
	// Snapshot stream after each shift
	output logic snap_valid,
	output logic [SNAP_WIDTH-1:0] snap_data,
	input wire logic snap_ready,
	output logic snap_space,
	output logic snap_overrun
);

	// ------------------------------------------------------------------
	// Edge detection on the shift clock pin
	// ------------------------------------------------------------------
	logic clk_prev_q;
	logic rise;
	logic gated_bit;

	// Previous pin level; reset high so a clock held high is not an edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			clk_prev_q <= CLK_PREV_RESET;
		end else begin
			clk_prev_q <= shift_clk;
		end
	end

	// Only a low-to-high change is an event
	assign rise = shift_clk & ~clk_prev_q;

	// Either input low blocks entry; both high admit a one
	assign gated_bit = serial_a & serial_b;

	// ------------------------------------------------------------------
	// Stage chain
	// ------------------------------------------------------------------
	logic [STAGE_COUNT-1:0] stage_q;

	// First stage: clear wins, else sample the gate on the rising edge
	// No else branch: with neither edge nor clear the stage keeps its level
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stage_q[FIRST_STAGE] <= STAGE_RESET[FIRST_STAGE];
		end else if (!clear_n) begin
			stage_q[FIRST_STAGE] <= STAGE_RESET[FIRST_STAGE];
		end else if (rise) begin
			stage_q[FIRST_STAGE] <= gated_bit;
		end
	end

	// Later stages copy their predecessor, one flop per stage
	for (genvar i = FIRST_STAGE + 1; i < STAGE_COUNT; i++) begin : g_stage
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				stage_q[i] <= STAGE_RESET[i];
			end else if (!clear_n) begin
				stage_q[i] <= STAGE_RESET[i];
			end else if (rise) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	// Parallel taps come straight from the stage flops
	assign stage_outputs = stage_q;
	assign stage_one_output = stage_q[FIRST_STAGE];
	assign stage_two_output = stage_q[FIRST_STAGE + 1];
	assign stage_seven_output = stage_q[LAST_STAGE - 1];
	assign stage_eight_output = stage_q[LAST_STAGE];

	// ------------------------------------------------------------------
	// Step tracking and snapshot push
	// ------------------------------------------------------------------
	shift_state_t state_q;
	logic push_valid;
	logic fifo_ready;
	logic overrun_q;

	// Remember what the chain did last cycle; a shift is pushed next cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
		end else if (!clear_n) begin
			state_q <= ST_CLEARED;
		end else if (rise) begin
			state_q <= ST_SHIFTED;
		end else begin
			state_q <= ST_IDLE;
		end
	end

	// Push the new contents once per shift, never on a clear
	always_comb begin
		case (state_q)
			ST_SHIFTED: push_valid = 1'b1;
			default: push_valid = 1'b0;
		endcase
	end

	// Sticky flag: a snapshot was lost because the buffer was full.
	// The chain itself never stalls, since the pins set its pace.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			overrun_q <= 1'b0;
		end else if (push_valid & ~fifo_ready) begin
			overrun_q <= 1'b1;
		end
	end

	assign snap_overrun = overrun_q;
	assign snap_space = fifo_ready;

	// Buffer between the chain and the stream consumer
	snap_fifo #(
		.WIDTH(SNAP_WIDTH),
		.DEPTH(SNAP_DEPTH)
	) u_snap_fifo (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.in_valid(push_valid),
		.in_data(stage_q),
		.in_ready(fifo_ready),
		.out_valid(snap_valid),
		.out_data(snap_data),
		.out_ready(snap_ready)
	);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------

	// A shift is followed by exactly one push of the shifted contents
	property p_shift_push;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n) |=> (push_valid && stage_q[LAST_STAGE:FIRST_STAGE+1] ==
			$past(stage_q[LAST_STAGE-1:FIRST_STAGE]));
	endproperty
	a_shift_push: assert property (p_shift_push) else $error("shift not pushed");

	// Clear empties all stages next cycle and keeps them empty
	property p_clear_low;
		@(posedge sys_clk) disable iff (!nrst)
		(!clear_n) [*2] |=> (stage_q == STAGE_RESET) && (stage_outputs == STAGE_RESET);
	endproperty
	a_clear_low: assert property (p_clear_low) else $error("clear did not zero");

	// Either gate input low means a zero enters
	property p_gate_block;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n && !(serial_a && serial_b)) |=> !stage_one_output;
	endproperty
	a_gate_block: assert property (p_gate_block) else $error("blocked bit entered");

	// Both gate inputs high means a one enters
	property p_gate_pass;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n && serial_a && serial_b) |=> stage_one_output;
	endproperty
	a_gate_pass: assert property (p_gate_pass) else $error("gated one lost");

	// No change without a rising edge or a clear
	property p_edge_only;
		@(posedge sys_clk) disable iff (!nrst)
		(clear_n && !rise) |=> $stable(stage_q);
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("stage moved off edge");

	// Last stage follows stage seven by one edge
	property p_shift_tail;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n) |=> stage_eight_output == $past(stage_seven_output);
	endproperty
	a_shift_tail: assert property (p_shift_tail) else $error("tail shift wrong");

	// Two quiet cycles keep the contents across both
	property p_hold;
		@(posedge sys_clk) disable iff (!nrst)
		(clear_n && !rise) ##1 (clear_n && !rise) |=> stage_q == $past(stage_q, 2);
	endproperty
	a_hold: assert property (p_hold) else $error("stage not held");

	// The entered bit is the gate sampled at the edge, not a later level
	property p_sample_at_edge;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n) |=> stage_one_output == $past(serial_a & serial_b);
	endproperty
	a_sample_at_edge: assert property (p_sample_at_edge) else $error("wrong sample");

	// A rejected push raises the sticky overrun flag
	property p_overrun;
		@(posedge sys_clk) disable iff (!nrst)
		(push_valid && !fifo_ready) |=> snap_overrun [*2];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	// Checks below look at clear, at each gate input alone, at the shift clock edges and at the stream side.
	// Clear is sampled, so its effect is due one sys_clk after it is seen.

	// One clear cycle is enough to empty every stage
	property p_clear_now;
		@(posedge sys_clk) disable iff (!nrst)
		(!clear_n) |=> (stage_q == STAGE_RESET);
	endproperty
	a_clear_now: assert property (p_clear_now) else $error("clear too slow");

	// A clear never produces a snapshot
	property p_clear_no_push;
		@(posedge sys_clk) disable iff (!nrst)
		(!clear_n) |=> !push_valid;
	endproperty
	a_clear_no_push: assert property (p_clear_no_push) else $error("clear pushed a word");

	// Input A low alone blocks entry
	property p_gate_a_low;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n && !serial_a) |=> !stage_one_output;
	endproperty
	a_gate_a_low: assert property (p_gate_a_low) else $error("input a did not block");

	// Input B low alone blocks entry
	property p_gate_b_low;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n && !serial_b) |=> !stage_one_output;
	endproperty
	a_gate_b_low: assert property (p_gate_b_low) else $error("input b did not block");

	// Input A high hands the decision to input B
	property p_enable_a;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n && serial_a) |=> stage_one_output == $past(serial_b);
	endproperty
	a_enable_a: assert property (p_enable_a) else $error("input b not passed");

	// Input B high hands the decision to input A
	property p_enable_b;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n && serial_b) |=> stage_one_output == $past(serial_a);
	endproperty
	a_enable_b: assert property (p_enable_b) else $error("input a not passed");

	// A falling shift clock moves nothing
	property p_fall_still;
		@(posedge sys_clk) disable iff (!nrst)
		($fell(shift_clk) && clear_n) |=> $stable(stage_q);
	endproperty
	a_fall_still: assert property (p_fall_still) else $error("falling edge shifted");

	// Second stage follows the first by one edge
	property p_shift_head;
		@(posedge sys_clk) disable iff (!nrst)
		(rise && clear_n) |=> stage_two_output == $past(stage_one_output);
	endproperty
	a_shift_head: assert property (p_shift_head) else $error("head shift wrong");

	// A push only ever follows a shift edge
	property p_push_after_shift;
		@(posedge sys_clk) disable iff (!nrst)
		push_valid |-> $past(rise) && $past(clear_n);
	endproperty
	a_push_after_shift: assert property (p_push_after_shift) else $error("push without shift");

	// Shifts are at least two cycles apart, so pushes never run back to back
	property p_push_once;
		@(posedge sys_clk) disable iff (!nrst)
		push_valid |=> !push_valid;
	endproperty
	a_push_once: assert property (p_push_once) else $error("double push");

	// Overrun stays up until reset
	property p_overrun_sticky;
		@(posedge sys_clk) disable iff (!nrst)
		snap_overrun |=> snap_overrun;
	endproperty
	a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun dropped");

	// An offered snapshot stands until it is taken
	property p_snap_hold;
		@(posedge sys_clk) disable iff (!nrst)
		(snap_valid && !snap_ready) |=> snap_valid && $stable(snap_data);
	endproperty
	a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed early");

endmodule : gated_serial_shift_register

// ### hw/shift_reg_pkg.sv
// Constants shared by the gated serial shift register and its snapshot FIFO
package shift_reg_pkg;

	// ------------------------------------------------------------------
	// Register geometry
	// ------------------------------------------------------------------
	localparam int STAGE_COUNT = 8;
	localparam int FIRST_STAGE = 0;
	localparam int LAST_STAGE = STAGE_COUNT - 1;
	localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 8'h00;

	// ------------------------------------------------------------------
	// Snapshot buffering
	// ------------------------------------------------------------------
	localparam int SNAP_DEPTH = 16;
	localparam int SNAP_WIDTH = STAGE_COUNT;

	// Idle level of the sampled shift clock, so release never looks like an edge
	localparam logic CLK_PREV_RESET = 1'b1;

	// Step state of the shift engine
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFTED,
		ST_CLEARED
	} shift_state_t;

endpackage : shift_reg_pkg

// ### hw/snap_fifo.sv
// Snapshot FIFO with a registered output stage and registered space flag
`timescale 1ns/1ps
module snap_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_COUNT = CW'(1);

	// ------------------------------------------------------------------
	// Storage and pointers
	// ------------------------------------------------------------------
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic space_q;
	logic ov_q;
	logic [WIDTH-1:0] od_q;
	logic push;
	logic pop_out;
	logic mem_rd;

	// Handshake terms; output stage refills only from storage
	assign push = in_valid & space_q;
	assign pop_out = ov_q & out_ready;
	assign mem_rd = (count_q != '0) & (~ov_q | pop_out);
	assign in_ready = space_q;
	assign out_valid = ov_q;
	assign out_data = od_q;

	// Occupancy after this cycle
	always_comb begin
		count_d = count_q;
		if (push & ~mem_rd) begin
			count_d = count_q + ONE_COUNT;
		end else if (~push & mem_rd) begin
			count_d = count_q - ONE_COUNT;
		end
	end

	// Write side
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// Pointers, count and the space flag kept as a flop
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			space_q <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
			end
			if (mem_rd) begin
				rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
			end
			count_q <= count_d;
			space_q <= (count_d != FULL_COUNT);
		end
	end

	// Registered output stage
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ov_q <= 1'b0;
			od_q <= '0;
		end else if (mem_rd) begin
			ov_q <= 1'b1;
			od_q <= mem_q[rd_ptr_q];
		end else if (pop_out) begin
			ov_q <= 1'b0;
		end
	end

	// Space may only drop once storage is full and the output stage holds a word
	property p_space_honest;
		@(posedge sys_clk) disable iff (!nrst)
		!space_q |-> (count_q == FULL_COUNT) && ov_q;
	endproperty
	a_space_honest: assert property (p_space_honest) else $error("fifo space flag wrong");

endmodule : snap_fifo
